// ---- rtl/flash_seq_defines.vh ----
// Register offsets, field positions, reset values and timing counts
// for the flash program/erase sequencer. Definitions only.
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH

// Register byte addresses on APB
`define OFS_CONTROL 12'h000
`define OFS_KEY 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00c
`define OFS_LATCH_INDEX 12'h010
`define OFS_LATCH_DATA 12'h014
`define OFS_TABLE_PAGE 12'h018
`define OFS_TABLE_OFFSET 12'h01c

// Control register fields
`define BIT_START 15
`define BIT_PE_ENABLE 14
`define BIT_SEQ_ERROR 13
`define BIT_ERASE_SEL 6
`define OPSEL_MSB 3
`define OPSEL_LSB 0
`define CONTROL_RESET 16'h0000

// Unlock key values
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define KEY_RESET 8'h00

// Operation codes
`define OP_BULK 4'hf
`define OP_GENERAL 4'hd
`define OP_SECURE 4'hc
`define OP_WORD 4'h3
`define OP_PAGE 4'h2
`define OP_ROW 4'h1
`define OP_CONFIG 4'h0

// Geometry
`define ROW_WORDS 64
`define PAGE_ROWS 8

// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_ERROR 1

// Operation time in nanoseconds and clock period
`define CLK_PERIOD_NS 100
`define PROG_TIME_NS 20000
`define ERASE_TIME_NS 400000
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/unlock_detector.v ----
// Watches key register writes and arms the unlock after 55h then AAh.
// Assumes one-cycle write pulses from the register slave on pclk.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defines.vh"
module unlock_detector (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Key writes
  input wire key_wr,
  input wire [7:0] key_val,
  // Consumed by a start attempt
  input wire consume,
  // Unlock state
  output reg armed_r
);
  reg first_seen_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_seen_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (key_wr) begin
      // A key write drops both stages unless it is 55h or the AAh that follows 55h
      first_seen_r <= (key_val == `KEY_FIRST);
      armed_r <= first_seen_r && (key_val == `KEY_SECOND);
    end else if (consume) begin
      first_seen_r <= 1'b0;
      armed_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/op_timer.v ----
// Down-counter that times one self-timed flash operation.
// Assumes load is a single-cycle pulse while the timer is idle.
`timescale 1ns/100ps
`default_nettype none
module op_timer #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire load,
  input wire [WIDTH-1:0] cycles,
  input wire abort,
  // Status
  output wire busy,
  output reg done_r
);
  reg [WIDTH-1:0] count_r;

  assign busy = (count_r != {WIDTH{1'b0}});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= {WIDTH{1'b0}};
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        count_r <= {WIDTH{1'b0}};
      end else if (load) begin
        count_r <= cycles;
      end else if (busy) begin
        count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
        if (count_r == {{(WIDTH-1){1'b0}}, 1'b1})
          done_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/flash_program_erase_sequencer.v ----
// Flash program/erase sequencer: control and key registers on APB,
// unlock sequence, row latch buffer, timed erase and program operations.
// Assumes one clock pclk; the flash array itself sits outside and
// follows the one-cycle command strobe with the page and latch contents.
// Key writes need not be adjacent on the bus, but any key write other
// than 55h in between disarms the unlock. Outputs all leave flip-flops.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defines.vh"
module flash_program_erase_sequencer #(
  parameter TIMER_WIDTH = 16,
  parameter PROG_CYCLES = `PROG_CYCLES,
  parameter ERASE_CYCLES = `ERASE_CYCLES,
  parameter ROW_WORDS = `ROW_WORDS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Core stall and interrupt
  output reg cpu_stall_r,
  output reg irq_r,
  // Flash array command
  output reg flash_cmd_r,
  output reg [3:0] flash_op_r,
  output reg flash_erase_r,
  output reg [15:0] flash_page_r,
  output reg [15:0] flash_offset_r,
  // Abort from the power supervisor terminates an operation
  input wire op_abort
);

  ////////////////////////////////////////////////////////////////////
  // Operation decode

  // Returns 1 for codes that do real work in the chosen mode
  // Reserved and no-operation codes fall through to zero
  function valid_op;
    input erase;
    input [3:0] op;
    begin
      if (erase)
        valid_op = (op == `OP_BULK) || (op == `OP_GENERAL) ||
          (op == `OP_SECURE) || (op == `OP_PAGE) ||
          (op == `OP_CONFIG);
      else
        valid_op = (op == `OP_WORD) || (op == `OP_ROW) || (op == `OP_CONFIG);
    end
  endfunction

  // Sticky status bit
  function w1c_next;
    input old;
    input set;
    input clr;
    begin
      w1c_next = set || (old && !clr);
    end
  endfunction

  // Unmapped or unaligned word address
  function addr_bad;
    input [11:0] addr;
    begin
      addr_bad = (addr > `OFS_TABLE_OFFSET) || (addr[1:0] != 2'h0);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers

  reg start_r;
  reg pe_enable_r;
  reg seq_error_r;
  reg erase_sel_r;
  reg [3:0] opsel_r;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;
  reg [5:0] latch_index_r;
  reg [23:0] latch_mem_r [0:ROW_WORDS-1];
  reg [15:0] table_page_r;
  reg [15:0] table_offset_r;
  reg [TIMER_WIDTH-1:0] cycles_nxt;
  integer i;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  // Pready is always high in the access cycle, so penable marks the access
  wire setup_cyc = psel && !penable;
  wire setup_rd = setup_cyc && !pwrite;
  wire wr_en = psel && penable && pwrite;
  wire hit_ctrl = (paddr == `OFS_CONTROL);
  wire status_wr = wr_en && (paddr == `OFS_IRQ_STATUS);
  wire mask_wr = wr_en && (paddr == `OFS_IRQ_MASK);
  wire key_wr = wr_en && (paddr == `OFS_KEY);
  wire ctrl_wr = wr_en && hit_ctrl;
  wire start_req = ctrl_wr && pwdata[`BIT_START] && !start_r;
  wire armed;
  wire timer_busy;
  wire timer_done;

  // Start honoured only when armed, enabled and the code is real
  wire start_ok = start_req && armed && pwdata[`BIT_PE_ENABLE] &&
    valid_op(pwdata[`BIT_ERASE_SEL], pwdata[`OPSEL_MSB:`OPSEL_LSB]);
  wire start_bad = start_req && !start_ok;
  // An abort while idle is ignored and flags nothing
  wire abort_hit = op_abort && start_r;

  // Timer length follows the erase selector of the start write
  always @* begin
    if (pwdata[`BIT_ERASE_SEL])
      cycles_nxt = ERASE_CYCLES[TIMER_WIDTH-1:0];
    else
      cycles_nxt = PROG_CYCLES[TIMER_WIDTH-1:0];
  end

  // Every start attempt made while idle, good or bad, uses up the unlock
  unlock_detector u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(key_wr),
    .key_val(pwdata[7:0]),
    .consume(start_req),
    .armed_r(armed)
  );

  op_timer #(.WIDTH(TIMER_WIDTH)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(start_ok),
    .cycles(cycles_nxt),
    .abort(abort_hit),
    .busy(timer_busy),
    .done_r(timer_done)
  );

  ////////////////////////////////////////////////////////////////////
  // Control register

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b0;
      pe_enable_r <= 1'b0;
      seq_error_r <= 1'b0;
      erase_sel_r <= 1'b0;
      opsel_r <= 4'h0;
    end else begin
      // Writes are refused while an operation runs
      if (ctrl_wr && !start_r) begin
        pe_enable_r <= pwdata[`BIT_PE_ENABLE];
        erase_sel_r <= pwdata[`BIT_ERASE_SEL];
        opsel_r <= pwdata[`OPSEL_MSB:`OPSEL_LSB];
      end
      // Error flag set wins over a software clear
      if (start_bad || abort_hit)
        seq_error_r <= 1'b1;
      else if (start_ok)
        seq_error_r <= 1'b0;
      else if (ctrl_wr && !start_r)
        seq_error_r <= pwdata[`BIT_SEQ_ERROR];
      // Start is set-only by software, cleared by hardware at the end
      if (start_ok)
        start_r <= 1'b1;
      else if (timer_done || abort_hit)
        start_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Row latches and address registers

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_index_r <= 6'h00;
      table_page_r <= 16'h0000;
      table_offset_r <= 16'h0000;
      for (i = 0; i < ROW_WORDS; i = i + 1)
        latch_mem_r[i] <= 24'h000000;
    end else if (wr_en && !start_r) begin
      // Frozen while the array is busy so the row it sees stays fixed
      if (paddr == `OFS_LATCH_INDEX)
        latch_index_r <= pwdata[5:0];
      if (paddr == `OFS_LATCH_DATA) begin
        // Auto-increment lets software stream a full row
        // Index wraps at the row length
        latch_mem_r[latch_index_r] <= pwdata[23:0];
        latch_index_r <= latch_index_r + 6'h01;
      end
      if (paddr == `OFS_TABLE_PAGE)
        table_page_r <= pwdata[15:0];
      if (paddr == `OFS_TABLE_OFFSET)
        table_offset_r <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      // Set wins over write-one-to-clear in the same cycle
      irq_status_r[`IRQ_DONE] <= w1c_next(irq_status_r[`IRQ_DONE], timer_done,
        status_wr && pwdata[`IRQ_DONE]);
      irq_status_r[`IRQ_ERROR] <= w1c_next(irq_status_r[`IRQ_ERROR], start_bad || abort_hit,
        status_wr && pwdata[`IRQ_ERROR]);
      // Mask shares the status layout
      if (mask_wr)
        irq_mask_r <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_stall_r <= 1'b0;
      irq_r <= 1'b0;
      flash_cmd_r <= 1'b0;
      flash_op_r <= 4'h0;
      flash_erase_r <= 1'b0;
      flash_page_r <= 16'h0000;
      flash_offset_r <= 16'h0000;
    end else begin
      // Stall covers the whole timed operation
      // and drops on the edge where the start bit clears
      cpu_stall_r <= start_ok || (timer_busy && !abort_hit && !timer_done);
      irq_r <= |(irq_status_r & irq_mask_r);
      flash_cmd_r <= start_ok;
      // Latched once so the array sees a stable request
      if (start_ok) begin
        flash_op_r <= pwdata[`OPSEL_MSB:`OPSEL_LSB];
        flash_erase_r <= pwdata[`BIT_ERASE_SEL];
        flash_page_r <= table_page_r;
        flash_offset_r <= table_offset_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped address

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // One fixed answer time keeps the master's timing simple
      pready <= setup_cyc;
      pslverr <= setup_cyc && addr_bad(paddr);
      // Read data is launched in setup so it stands through the access
      prdata <= 32'h00000000;
      if (setup_rd) begin
        case (paddr)
          `OFS_CONTROL: prdata <= {16'h0000, start_r, pe_enable_r, seq_error_r,
            6'h00, erase_sel_r, 2'h0, opsel_r};
          `OFS_KEY: prdata <= 32'h00000000;
          `OFS_IRQ_STATUS: prdata <= {30'h0, irq_status_r};
          `OFS_IRQ_MASK: prdata <= {30'h0, irq_mask_r};
          `OFS_LATCH_INDEX: prdata <= {26'h0, latch_index_r};
          `OFS_LATCH_DATA: prdata <= {8'h00, latch_mem_r[latch_index_r]};
          `OFS_TABLE_PAGE: prdata <= {16'h0000, table_page_r};
          `OFS_TABLE_OFFSET: prdata <= {16'h0000, table_offset_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/core_apb_model.sv ----
// APB master standing for the core: register and table reads and writes.
// Assumes pclk and presetn come from the bench.
`timescale 1ns/100ps
`default_nettype none
module core_apb_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // Released lines change, so a stale value is never trusted
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- tb/flash_program_erase_sequencer_chk.sv ----
// Port checks: unlock, operation codes, stall timing, abort.
// Assumes binding into the sequencer; counts from its parameters.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defines.vh"
module flash_program_erase_sequencer_chk #(
  parameter PROG_CYCLES = 200,
  parameter ERASE_CYCLES = 4000
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  // Operation
  input wire cpu_stall_r,
  input wire flash_cmd_r,
  input wire [3:0] flash_op_r,
  input wire flash_erase_r,
  input wire op_abort
);
  wire acc = psel && penable && pready && pwrite;
  wire sw = acc && paddr == `OFS_CONTROL && pwdata[15] && !cpu_stall_r;
  wire [15:0] want = flash_erase_r ? 16'(ERASE_CYCLES) : 16'(PROG_CYCLES);
  reg last55_r, arm_r, ok_r, ab_r;
  reg [15:0] cnt_r;
  // Shadow of the unlock state, seen only through bus traffic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {last55_r, arm_r, ok_r, ab_r, cnt_r} <= 20'h0;
    end else begin
      cnt_r <= cpu_stall_r ? cnt_r + 16'h1 : 16'h0;
      ab_r <= (op_abort & cpu_stall_r) | (ab_r & ~flash_cmd_r);
      if (acc && paddr == `OFS_KEY) begin
        last55_r <= pwdata[7:0] == 8'h55;
        arm_r <= last55_r && pwdata[7:0] == 8'haa;
      end
      if (sw) begin
        {last55_r, arm_r, ok_r} <= {2'b00, arm_r};
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_key_zero;
    psel && penable && pready && !pwrite && paddr == `OFS_KEY |-> prdata == 32'h0;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("key read not zero");
  property p_disabled;
    sw && !pwdata[14] |=> !flash_cmd_r;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled start ran");
  property p_nop_codes;
    sw && pwdata[6] && (pwdata[3:0] == 4'h3 || pwdata[3:0] == 4'h1) |=> !flash_cmd_r;
  endproperty
  a_nop_codes: assert property (p_nop_codes) else $error("no-op code ran");
  property p_erase_codes;
    flash_cmd_r && flash_erase_r |-> flash_op_r inside {4'hf, 4'hd, 4'hc, 4'h2, 4'h0};
  endproperty
  a_erase_codes: assert property (p_erase_codes) else $error("bad erase code");
  property p_prog_codes;
    flash_cmd_r && !flash_erase_r |-> flash_op_r inside {4'h3, 4'h1, 4'h0};
  endproperty
  a_prog_codes: assert property (p_prog_codes) else $error("bad program code");
  property p_unlock;
    flash_cmd_r |-> ok_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("start without unlock");
  property p_stall;
    flash_cmd_r |-> cpu_stall_r ##1 (cpu_stall_r && !flash_cmd_r);
  endproperty
  a_stall: assert property (p_stall) else $error("stall not with command");
  property p_duration;
    $fell(cpu_stall_r) && !ab_r |-> cnt_r + 16'h1 >= want && cnt_r <= want + 16'h1;
  endproperty
  a_duration: assert property (p_duration) else $error("stall length");
  property p_abort;
    op_abort && cpu_stall_r |-> ##[1:2] !cpu_stall_r;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
endmodule
bind flash_program_erase_sequencer flash_program_erase_sequencer_chk #(
  .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) i_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .cpu_stall_r, .flash_cmd_r,
  .flash_op_r, .flash_erase_r, .op_abort);
`default_nettype wire

// ---- tb/flash_program_erase_sequencer_tb.sv ----
// Bench: every operation code, unlock order, abort, interrupt.
// Assumes the core model and checker; short operation times.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defines.vh"
module flash_program_erase_sequencer_tb;
  logic pclk = 0;
  logic presetn = 0;
  logic op_abort = 0;
  wire psel, penable, pwrite, pready, pslverr, cpu_stall_r, irq_r, flash_cmd_r, flash_erase_r;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] flash_op_r;
  wire [15:0] flash_page_r, flash_offset_r;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rv;
  logic ev;
  always #50 pclk = ~pclk;
  core_apb_model i_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  flash_program_erase_sequencer #(.PROG_CYCLES(5), .ERASE_CYCLES(10)) i_dut (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu_stall_r, .irq_r, .flash_cmd_r, .flash_op_r, .flash_erase_r, .flash_page_r,
    .flash_offset_r, .op_abort);
  ////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_core.xfer(1'b1, a, d, rv, ev);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    i_core.xfer(1'b0, a, 32'h0, rv, ev);
    check(rv, exp, what);
  endtask
  task wait_idle;
    repeat (40) begin
      @(posedge pclk);
      #1;
      if (cpu_stall_r !== 1'b1) break;
    end
  endtask
  task go(input logic [7:0] k1, input logic [7:0] k2, input logic e, input logic [3:0] op,
          input logic en, input logic exp);
    wr(`OFS_KEY, {24'h0, k1});
    wr(`OFS_KEY, {24'h0, k2});
    wr(`OFS_CONTROL, {16'h0, 1'b1, en, 7'h0, e, 2'h0, op});
    #1;
    check(flash_cmd_r, exp, "command");
    if (exp) begin
      check({cpu_stall_r, flash_erase_r, flash_op_r, flash_page_r},
            {1'b1, e, op, 16'h1234}, "issued op");
      check(flash_offset_r, 32'h0040, "issued offset");
      rd(`OFS_CONTROL, {16'h0, 2'b11, 7'h0, e, 2'h0, op}, "busy control");
    end
    // Core keeps off the bus until the operation is over
    wait_idle;
    rd(`OFS_CONTROL, {16'h0, 1'b0, en, ~exp, 6'h0, e, 2'h0, op}, "control");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////
  task run_regs;
    rd(`OFS_CONTROL, 32'h0, "control reset");
    wr(`OFS_KEY, 32'h0000ff55);
    rd(`OFS_KEY, 32'h0, "key");
    wr(`OFS_TABLE_PAGE, 32'h1234);
    wr(`OFS_TABLE_OFFSET, 32'h0040);
    wr(`OFS_LATCH_INDEX, 32'h5);
    for (int i = 0; i < 64; i++) wr(`OFS_LATCH_DATA, i);
    rd(`OFS_LATCH_INDEX, 32'h5, "latch index wrap");
    wr(`OFS_LATCH_INDEX, 32'h7);
    rd(`OFS_LATCH_DATA, 32'h2, "latch word");
  endtask
  task run_codes;
    for (int i = 0; i < 32; i++) begin
      go(8'h55, 8'haa, i[4], i[3:0], 1'b1, i[4] ? (i[3:0] inside {4'hf, 4'hd, 4'hc, 4'h2,
         4'h0}) : (i[3:0] inside {4'h3, 4'h1, 4'h0}));
    end
  endtask
  task run_unlock;
    go(8'h55, 8'haa, 1'b1, 4'h2, 1'b0, 1'b0);
    go(8'haa, 8'h55, 1'b1, 4'h2, 1'b1, 1'b0);
    wr(`OFS_KEY, 32'h55);
    go(8'h33, 8'haa, 1'b1, 4'h2, 1'b1, 1'b0);
  endtask
  task run_abort;
    wr(`OFS_KEY, 32'h55);
    wr(`OFS_KEY, 32'haa);
    wr(`OFS_CONTROL, 32'hc042);
    // Abort lands inside the operation, clear of the command pulse
    repeat (2) @(posedge pclk);
    check(cpu_stall_r, 1'b1, "stall before abort");
    op_abort <= 1'b1;
    @(posedge pclk);
    op_abort <= 1'b0;
    #1;
    check(cpu_stall_r, 1'b0, "stall after abort");
    wait_idle;
    rd(`OFS_CONTROL, 32'h6042, "aborted");
    rd(`OFS_IRQ_STATUS, 32'h3, "status");
    wr(`OFS_IRQ_STATUS, 32'h3);
    rd(`OFS_IRQ_STATUS, 32'h0, "status cleared");
  endtask
  task run_irq;
    wr(`OFS_IRQ_MASK, 32'h1);
    go(8'h55, 8'haa, 1'b0, 4'h1, 1'b1, 1'b1);
    @(posedge pclk);
    #1;
    check(irq_r, 1'b1, "irq raised");
    wr(`OFS_IRQ_MASK, 32'h2);
    @(posedge pclk);
    #1;
    check(irq_r, 1'b0, "irq masked");
    go(8'h55, 8'h55, 1'b1, 4'h2, 1'b1, 1'b0);
    check(irq_r, 1'b1, "irq on error");
  endtask
  task run_unmapped;
    i_core.xfer(1'b0, 12'h020, 32'h0, rv, ev);
    check(ev, 1'b1, "unmapped");
    rd(`OFS_IRQ_MASK, 32'h2, "mask");
    check(ev, 1'b0, "mapped");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    run_regs;
    run_codes;
    run_unlock;
    run_abort;
    run_irq;
    run_unmapped;
    complete_run;
  end
endmodule
`default_nettype wire
